// File: rtl/spcc_pkg.sv
package spcc_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int unsigned NUM_OUTPUTS = 10;
  // select value 1 picks input_clock_a, 0 picks input_clock_b
  localparam logic        SEL_CLOCK_A = 1'b1;
  localparam logic        SEL_CLOCK_B = 1'b0;
  localparam logic [9:0]  SEL_RESET   = 10'h000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CORE_CLK_MHZ   = 100;
  localparam int unsigned SERIAL_MAX_MHZ = 20;
  // least core cycles per serial clock period
  localparam int unsigned SERIAL_MIN_CYC = CORE_CLK_MHZ / SERIAL_MAX_MHZ;
  localparam int unsigned SYNC_STAGES    = 2;
endpackage

// File: rtl/spcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spcc_sync
  import spcc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // async level in, synchronised level out
  input  wire logic async_i,
  output var  logic sync_o
);
  logic meta_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/spcc_top.sv
// Operation
// - ten outputs, each routes one of two input clocks by own select bit
// - ten-bit word holds selects; output mux switches asynchronously
// - load_latch copies shifted word to latches; routing changes only then or at reset
// - shifted data leaves on cascade_out to chain further devices
// - select 0 routes input_clock_b, select 1 routes input_clock_a
// - unconnected load_latch reads as low
// - unconnected serial_clk and serial_in read as low
`timescale 1ns/1ps
`default_nettype none
module spcc_top
  import spcc_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  // serial programming port
  input  wire logic                   serial_clk_i,
  input  wire logic                   serial_in_i,
  input  wire logic                   load_latch_i,
  output var  logic                   cascade_out_o,
  // clock crosspoint
  input  wire logic                   input_clock_a_i,
  input  wire logic                   input_clock_b_i,
  output logic [NUM_OUTPUTS-1:0]      clk_out_o,
  output logic [NUM_OUTPUTS-1:0]      clk_out_n_o,
  // latched routing word
  output var  logic [NUM_OUTPUTS-1:0] select_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // floating pins are pulled low outside; reset state is low as well
  logic sclk_s;
  logic sdat_s;
  logic load_s;

  spcc_sync u_sync_sclk (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (serial_clk_i),
    .sync_o     (sclk_s)
  );
  spcc_sync u_sync_sdat (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (serial_in_i),
    .sync_o     (sdat_s)
  );
  spcc_sync u_sync_load (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (load_latch_i),
    .sync_o     (load_s)
  );

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  logic sclk_q;
  logic load_q;
  logic sdat_q;
  logic sclk_rise;
  logic load_rise;

  // previous serial clock level, low after reset like the idle pin
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  // previous load level, so a held high level loads only once
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load_s;
    end
  end

  // serial data one cycle behind, well inside its setup window
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sdat_q <= 1'b0;
    end else begin
      sdat_q <= sdat_s;
    end
  end

  // data is taken one cycle late so it matches the clock edge alignment
  assign sclk_rise = sclk_s & ~sclk_q;
  assign load_rise = load_s & ~load_q;

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  // first bit in travels up to bit 9 after ten serial clock rises
  logic [NUM_OUTPUTS-1:0] shift_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_q <= SEL_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[NUM_OUTPUTS-2:0], sdat_q};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cascade_out_o <= 1'b0;
    end else begin
      cascade_out_o <= shift_q[NUM_OUTPUTS-1];
    end
  end

  // ----------------------------------------
  // select latches
  // ----------------------------------------
  // only the rise of load_latch loads; a held level changes nothing
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      select_o <= SEL_RESET;
    end else if (load_rise) begin
      select_o <= shift_q;
    end
  end

  // ----------------------------------------
  // output multiplexers
  // ----------------------------------------
  // purely combinational: no resync to either input clock, glitches possible
  always_comb begin
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      if (select_o[i] == SEL_CLOCK_A) begin
        clk_out_o[i] = input_clock_a_i;
      end else begin
        clk_out_o[i] = input_clock_b_i;
      end
    end
  end

  // inverted leg of each differential pair
  assign clk_out_n_o = ~clk_out_o;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // reset and pin defaults
  a_idle_low: assert property (
    @(posedge core_clk_i)
    rst_i |=> !sclk_s && !sdat_s && !load_s)
    else $error("synchronised pin not low after reset");
  a_reset_route: assert property (
    @(posedge core_clk_i)
    rst_i |=> select_o == SEL_RESET)
    else $error("select word not cleared by reset");

  // select latches
  a_latch_on_load: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    load_rise |=> select_o == $past(shift_q))
    else $error("select not loaded on load_latch");
  a_latch_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !load_rise |=> $stable(select_o))
    else $error("select changed without load_latch");
  a_latch_level: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    load_s && load_q |=> $stable(select_o))
    else $error("held load_latch level loaded again");
  a_latch_source: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $changed(select_o) |-> $past(load_rise))
    else $error("select changed with no load edge");

  // shift register and cascade
  a_shift_step: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    sclk_rise |=> shift_q[0] == $past(sdat_q))
    else $error("serial bit not shifted in");
  a_shift_body: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    sclk_rise |=> shift_q[NUM_OUTPUTS-1:1] == $past(shift_q[NUM_OUTPUTS-2:0]))
    else $error("shift register stages did not move up");
  a_shift_hold: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !sclk_rise |=> $stable(shift_q))
    else $error("shift register moved without serial clock");
  a_edge_single: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    sclk_rise |=> !sclk_rise)
    else $error("one serial clock rise seen twice");
  a_cascade_tail: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    ##1 cascade_out_o == $past(shift_q[NUM_OUTPUTS-1]))
    else $error("cascade_out does not follow last stage");
  a_cascade_move: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $changed(cascade_out_o) |-> $past(sclk_rise, 2))
    else $error("cascade_out moved without a shift");

  // output routing
  a_route_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    select_o[0] |-> clk_out_o[0] == input_clock_a_i)
    else $error("output 0 not on clock a");
  a_route_b: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !select_o[9] |-> clk_out_o[9] == input_clock_b_i)
    else $error("output 9 not on clock b");
  a_out_diff: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    clk_out_n_o == ~clk_out_o)
    else $error("differential pair mismatch");

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_route
      a_route_each: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        clk_out_o[g] == (select_o[g] ? input_clock_a_i : input_clock_b_i))
        else $error("output not on its selected clock");
    end
  endgenerate
endmodule
`default_nettype wire

// File: sim/spcc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module spcc_ctrl_model (
  // serial programming lines
  output var logic serial_clk_o,
  output var logic serial_in_o,
  output var logic load_latch_o
);
  // lines rest low, as the pull-downs leave them
  initial begin
    serial_clk_o = 1'b0;
    serial_in_o  = 1'b0;
    load_latch_o = 1'b0;
  end
  // msb first, 125 ns serial period, clock still between frames
  task automatic shift_word(input logic [9:0] w);
    for (int i = 9; i >= 0; i--) begin
      serial_in_o = w[i];
      #62.5 serial_clk_o = 1'b1;
      #62.5 serial_clk_o = 1'b0;
    end
    serial_in_o = 1'b0;
  endtask
  // load only once all ten bits are in
  task automatic load_word();
    #62.5 load_latch_o = 1'b1;
    #62.5 load_latch_o = 1'b0;
    #62.5;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_spcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spcc_top;
  import spcc_pkg::*;
  logic                   core_clk_i = 1'b0;
  logic                   rst_i      = 1'b1;
  logic                   clk_a      = 1'b0;
  logic                   clk_b      = 1'b0;
  wire  logic             sclk, sdin, load_latch;
  logic                   casc;
  logic [NUM_OUTPUTS-1:0] q, qn, sel;
  int                     bad_count  = 0;
  int                     compares   = 0;
  always #5 core_clk_i = ~core_clk_i;
  always #2.3 clk_a = ~clk_a;
  always #3.7 clk_b = ~clk_b;
  spcc_ctrl_model ctl_u (.serial_clk_o(sclk), .serial_in_o(sdin),
    .load_latch_o(load_latch));
  spcc_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .serial_clk_i(sclk), .serial_in_i(sdin), .load_latch_i(load_latch),
    .cascade_out_o(casc), .input_clock_a_i(clk_a),
    .input_clock_b_i(clk_b), .clk_out_o(q), .clk_out_n_o(qn),
    .select_o(sel));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // offset keeps samples clear of the source clock edges
  task automatic check_route(input logic [9:0] w);
    logic [9:0] exp_q;
    repeat (3) begin
      @(posedge core_clk_i);
      #1.05;
      exp_q = (w & {10{clk_a}}) | (~w & {10{clk_b}});
      check(sel, w);
      check(q, exp_q);
      check(qn, ~exp_q);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    check_route(SEL_RESET);
    check({9'h000, casc}, 10'h000);
  endtask
  // reset in mid-run drops routing back to clock b and clears cascade
  task automatic t_reset_mid();
    @(posedge core_clk_i);
    #1 rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    check_route(SEL_RESET);
    check({9'h000, casc}, 10'h000);
  endtask
  // routing holds the old word while bits shift, changes at load
  task automatic t_program(input logic [9:0] w, input logic [9:0] prev);
    ctl_u.shift_word(w);
    check_route(prev);
    check({9'h000, casc}, {9'h000, w[9]});
    ctl_u.load_word();
    check_route(w);
  endtask
  initial begin
    #20000;
    bad_count++;
    final_report();
  end
  initial begin
    t_reset();
    t_program(10'h2b5, SEL_RESET);
    t_program(10'h14a, 10'h2b5);
    t_program(10'h3ff, 10'h14a);
    t_reset_mid();
    t_program(10'h155, SEL_RESET);
    final_report();
  end
endmodule
`default_nettype wire
